// >>> hdl/ee_pkg.sv
// Shared constants and types for the two-wire EEPROM slave front end
package ee_pkg;

  // Slave address byte layout
  localparam logic [3:0] DEV_PREFIX    = 4'ha;   // Fixed upper nibble
  localparam int         PREFIX_MSB    = 7;
  localparam int         PREFIX_LSB    = 4;
  localparam int         STRAP_MSB     = 3;
  localparam int         STRAP_LSB     = 1;
  localparam int         RW_BIT        = 0;      // 1 = read, 0 = write

  // Array and page geometry
  localparam int         ADDR_W        = 13;     // 8192 bytes
  localparam int         PAGE_W        = 5;      // 32-byte page
  localparam int         PAGE_BYTES    = 32;
  localparam int         HI_ADDR_W     = ADDR_W - 8;
  localparam logic [3:0] BIT_ACK       = 4'h8;   // Count value of the ack slot

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [7:0]        BYTE_RST = 8'h00;

  // Self-timed programming window, longest time rounds down
  localparam int         PROG_TIME_US  = 5000;   // 5 ms
  localparam int         CLK_KHZ       = 10000;  // 10 MHz core clock
  localparam int         PROG_CYCLES_DEF = (PROG_TIME_US * CLK_KHZ) / 1000;

  // Bus-side phases of the slave
  typedef enum logic [2:0] {
    PH_IDLE,     // Standby, waiting for start
    PH_DEVADR,   // Receiving slave address
    PH_WORDHI,   // Receiving upper byte address
    PH_WORDLO,   // Receiving lower byte address
    PH_WRDATA,   // Receiving page data
    PH_RDDATA,   // Sending array data
    PH_IGNORE    // Released until next start
  } ee_phase_t;

  // Page-local increment: upper bits stay, low five bits wrap
  function automatic logic [ADDR_W-1:0] ee_page_inc(input logic [ADDR_W-1:0] a);
    ee_page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 5'h01};
  endfunction : ee_page_inc

endpackage : ee_pkg

// >>> hdl/ee_pair_fifo.sv
// Two-entry valid/ready buffer between page drain and array writer
`timescale 1ns/10ps
module ee_pair_fifo
  import ee_pkg::*;
#(
  parameter int W = 21
)(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic         inValid,
  output      logic         inReady,
  input  wire logic [W-1:0] inData,
  output      logic         outValid,
  input  wire logic         outReady,
  output      logic [W-1:0] outData
);

  logic [W-1:0] slot [2];   // Storage, flip-flops
  logic         wrIdx;      // Next slot to fill
  logic         rdIdx;      // Next slot to drain
  logic [1:0]   fill;       // Entries held

  wire pushOk = inValid & inReady;
  wire popOk  = outValid & outReady;

  // Honest flags straight from the fill count
  assign inReady  = (fill != 2'h2);
  assign outValid = (fill != 2'h0);
  assign outData  = slot[rdIdx];

  // Pointers and fill count
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      wrIdx <= 1'b0;
      rdIdx <= 1'b0;
      fill  <= 2'h0;
    end
    else if (clkEn)
    begin
      wrIdx <= wrIdx ^ pushOk;
      rdIdx <= rdIdx ^ popOk;
      fill  <= fill + {1'b0, pushOk} - {1'b0, popOk};
    end
  end

  // Data slots, written only on an accepted push
  always_ff @(posedge core_clk)
  begin
    if (clkEn && pushOk)
      slot[wrIdx] <= inData;
  end

endmodule : ee_pair_fifo

// >>> hdl/ee_two_wire_slave.sv
// Two-wire EEPROM slave: address decode, page write, reads, program timing
`timescale 1ns/10ps
module ee_two_wire_slave
  import ee_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
)(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output      logic              sdaOut,
  output      logic              sdaOe,
  input  wire logic              select_strap_bit0,
  input  wire logic              select_strap_bit1,
  input  wire logic              select_strap_bit2,
  input  wire logic              writeProtect,
  output      logic [ADDR_W-1:0] memRdAddr,
  input  wire logic [7:0]        memRdData,
  output      logic              progValid,
  input  wire logic              progReady,
  output      logic [ADDR_W-1:0] progAddr,
  output      logic [7:0]        progData,
  output      logic              busy,
  output      logic              standby
);

  // Pin synchronisers: stage 0 feeds stage 1 only
  logic [1:0]        sclSync;      // Clock pin sync chain
  logic [1:0]        sdaSync;      // Data pin sync chain
  logic [1:0]        wpSync;       // Write protect sync chain
  logic [2:0]        strapMeta;    // Strap first stage
  logic [2:0]        strapSync;    // Strap second stage
  logic              sclPrev;      // Clock one cycle back
  logic              sdaPrev;      // Data one cycle back

  // Protocol state
  ee_phase_t         phase;        // Current bus phase
  ee_phase_t         next_phase;   // Phase after this cycle
  logic [3:0]        bitCnt;       // Rising edges since byte start
  logic [7:0]        rxByte;       // Shift-in register
  logic [7:0]        txShift;      // Shift-out register
  logic              loadTx;       // Fetch next array byte
  logic [ADDR_W-1:0] addrCnt;      // Internal address counter
  logic [HI_ADDR_W-1:0] addrHi;    // Upper byte address, held

  // Page buffer and programming
  logic [7:0]        pageBuf [PAGE_BYTES];  // Buffered page bytes
  logic [PAGE_BYTES-1:0] pageUsed; // Positions written this page
  logic              pendWrite;    // Data bytes await a stop
  logic              progBusy;     // Internal cycle running
  logic [PAGE_W:0]   drainIdx;     // Drain position, MSB = done
  logic [31:0]       progTimer;    // Cycles since programming began
  logic              pushValid;    // Drain offers a byte
  logic              pushReady;    // Buffer accepts a byte

  // Sampled bus events
  wire sclHi    = sclSync[1];
  wire sdaNow   = sdaSync[1];
  wire sclRise  = sclHi & ~sclPrev;
  wire sclFall  = ~sclHi & sclPrev;
  wire startDet = sclHi & sclPrev & sdaPrev & ~sdaNow;
  wire stopDet  = sclHi & sclPrev & ~sdaPrev & sdaNow;
  wire byteDone = sclFall & (bitCnt == BIT_ACK);        // Enter ack slot
  wire ackRise  = sclRise & (bitCnt == BIT_ACK);        // Ack bit sampled
  // Address decode of the received byte
  wire prefixOk  = (rxByte[PREFIX_MSB:PREFIX_LSB] == DEV_PREFIX);
  wire strapOk   = (rxByte[STRAP_MSB:STRAP_LSB] == strapSync);
  wire devMatch  = prefixOk & strapOk & ~progBusy;
  wire readReq   = rxByte[RW_BIT];
  wire masterAck = ~sdaNow;                             // Low = more data
  // Ack decision for a completed byte
  wire ackNow = ((phase == PH_DEVADR) & devMatch)
              | (phase == PH_WORDHI)
              | (phase == PH_WORDLO)
              | (phase == PH_WRDATA);

  // Programming start and end conditions
  wire progStart = stopDet & (phase == PH_WRDATA) & pendWrite
                 & ~wpSync[1];
  wire timerDone = (progTimer >= PROG_CYCLES - 1);
  wire drainDone = drainIdx[PAGE_W];
  wire progDone  = progBusy & timerDone & drainDone & ~progValid;
  wire [PAGE_W-1:0] drainPos = drainIdx[PAGE_W-1:0];

  // Open drain: only ever pulls low
  assign sdaOut    = 1'b0;
  assign memRdAddr = addrCnt;
  assign busy      = progBusy;

  // Two flip-flops on every pin before use
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sclSync   <= 2'h3;
      sdaSync   <= 2'h3;
      wpSync    <= 2'h0;
      strapMeta <= 3'h0;
      strapSync <= 3'h0;
      sclPrev   <= 1'b1;
      sdaPrev   <= 1'b1;
    end
    else if (clkEn)
    begin
      sclSync   <= {sclSync[0], sclIn};
      sdaSync   <= {sdaSync[0], sdaIn};
      wpSync    <= {wpSync[0], writeProtect};
      strapMeta <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
      strapSync <= strapMeta;
      sclPrev   <= sclSync[1];
      sdaPrev   <= sdaSync[1];
    end
  end

  // Phase sequencing; start wins over everything
  always_comb
  begin
    next_phase = phase;
    if (startDet)
      next_phase = PH_DEVADR;
    else if (stopDet)
      next_phase = PH_IDLE;
    else if (byteDone)
    begin
      unique case (phase)
        PH_DEVADR:
          if (!devMatch)
            next_phase = PH_IGNORE;
          else if (readReq)
            next_phase = PH_RDDATA;
          else
            next_phase = PH_WORDHI;
        PH_WORDHI: next_phase = PH_WORDLO;
        PH_WORDLO: next_phase = PH_WRDATA;
        default:   next_phase = phase;                  // Data phases hold at a byte end; a read NAK exits below
      endcase
    end
    else if (ackRise && phase == PH_RDDATA && !masterAck)
      next_phase = PH_IGNORE;
  end

  // Phase register, bit counter and receive shifter
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      phase  <= PH_IDLE;
      bitCnt <= 4'h0;
      rxByte <= BYTE_RST;
    end
    else if (clkEn)
    begin
      phase <= next_phase;
      if (startDet)
        bitCnt <= 4'h0;
      else if (sclRise)
      begin
        bitCnt <= (bitCnt == BIT_ACK) ? 4'h0 : bitCnt + 4'h1;
        if (bitCnt != BIT_ACK)
          rxByte <= {rxByte[6:0], sdaNow};
      end
    end
  end

  // Data line drive, set on clock falls, released at a start or stop
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sdaOe <= 1'b0;
    else if (clkEn)
    begin
      if (startDet || stopDet)
        sdaOe <= 1'b0;                                  // Release at frame edges
      else if (byteDone)
        sdaOe <= ackNow;
      else if (sclFall)
        sdaOe <= (phase == PH_RDDATA) & ~txShift[7];
    end
  end

  // Fetch on a low ack slot, then shift out on falls
  // Our own address ack also reads low, so one fetch per byte, never two
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      loadTx  <= 1'b0;
      txShift <= 8'hff;
    end
    else if (clkEn)
    begin
      loadTx <= ackRise & (phase == PH_RDDATA) & masterAck;
      if (loadTx)
        txShift <= memRdData;
      else if (sclFall && phase == PH_RDDATA && bitCnt != BIT_ACK)
        txShift <= {txShift[6:0], 1'b1};
    end
  end

  // Address counter: loads, page wrap on write, full wrap on read
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      addrCnt <= ADDR_RST;
      addrHi  <= '0;
    end
    else if (clkEn)
    begin
      if (loadTx)
        addrCnt <= addrCnt + 13'h0001;
      else if (byteDone && phase == PH_WORDHI)
        addrHi <= rxByte[HI_ADDR_W-1:0];
      else if (byteDone && phase == PH_WORDLO)
        addrCnt <= {addrHi, rxByte};
      else if (byteDone && phase == PH_WRDATA)
        addrCnt <= ee_page_inc(addrCnt);
    end
  end

  // Page buffer, occupancy and pending-write flag
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pageUsed  <= '0;
      pendWrite <= 1'b0;
    end
    else if (clkEn)
    begin
      if (byteDone && phase == PH_WORDLO)
        pageUsed <= '0;                                 // Fresh page per write
      else if (byteDone && phase == PH_WRDATA)
      begin
        pageUsed[addrCnt[PAGE_W-1:0]] <= 1'b1;
        pageBuf[addrCnt[PAGE_W-1:0]]  <= rxByte;        // Wrap overwrites
        pendWrite <= 1'b1;
      end
      // A start or stop closes the write either way
      if (startDet || stopDet)
        pendWrite <= 1'b0;
    end
  end

  // Drain offers every used position, in order
  assign pushValid = progBusy & ~drainDone & pageUsed[drainPos];

  // Programming sequencer: drain and timer run together
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      progBusy  <= 1'b0;
      drainIdx  <= '0;
      progTimer <= '0;
    end
    else if (clkEn)
    begin
      if (progStart)
      begin
        progBusy  <= 1'b1;
        drainIdx  <= '0;
        progTimer <= '0;
      end
      else if (progDone)
        progBusy <= 1'b0;
      else if (progBusy)
      begin
        if (!timerDone)
          progTimer <= progTimer + 32'h1;
        // Unused positions skip; used ones wait for the buffer
        if (!drainDone && (!pageUsed[drainPos] || pushReady))
          drainIdx <= drainIdx + 6'h01;
      end
    end
  end

  // Standby tracking
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      standby <= 1'b1;
    else if (clkEn)
    begin
      if (progDone)
        standby <= 1'b1;
      else if (startDet || progStart)
        standby <= 1'b0;
      else if (stopDet && !progBusy)
        standby <= 1'b1;
    end
  end

  // Buffer absorbs writer stalls so no byte is lost
  ee_pair_fifo #(
    .W (ADDR_W + 8)
  ) u_prog_buf (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   ({addrCnt[ADDR_W-1:PAGE_W], drainPos, pageBuf[drainPos]}),
    .outValid (progValid),
    .outReady (progReady),
    .outData  ({progAddr, progData})
  );

endmodule : ee_two_wire_slave

// >>> verif/ee_two_wire_slave_properties.sv
// Port-level checks for the two-wire EEPROM slave
`timescale 1ns/10ps
module ee_two_wire_slave_properties
  import ee_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 600
)(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              clkEn,
  input wire logic              sclIn,
  input wire logic              sdaIn,
  input wire logic              sdaOut,
  input wire logic              sdaOe,
  input wire logic              select_strap_bit0,
  input wire logic              select_strap_bit1,
  input wire logic              select_strap_bit2,
  input wire logic              writeProtect,
  input wire logic [ADDR_W-1:0] memRdAddr,
  input wire logic [7:0]        memRdData,
  input wire logic              progValid,
  input wire logic              progReady,
  input wire logic [ADDR_W-1:0] progAddr,
  input wire logic [7:0]        progData,
  input wire logic              busy,
  input wire logic              standby
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Programming holds for a while once started
  sequence s_prog_run;
    busy [*8];
  endsequence
  // Window is bounded even with a slow array writer
  sequence s_prog_end;
    ##[1:1000] !busy;
  endsequence
  a_pin_open_drain: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data moved while clock high");
  a_prog_hold: assert property (progValid && !progReady |=>
    progValid && $stable(progAddr) && $stable(progData))
    else $error("stalled array write changed");
  a_busy_deaf: assert property (busy |-> !$rose(sdaOe))
    else $error("answer while programming");
  a_busy_awake: assert property (busy |-> !standby)
    else $error("standby while programming");
  a_end_standby: assert property ($fell(busy) |-> standby)
    else $error("no standby after programming");
  a_prog_min: assert property ($rose(busy) |-> s_prog_run)
    else $error("programming cut short");
  a_prog_max: assert property ($rose(busy) |-> s_prog_end)
    else $error("programming overran");
endmodule : ee_two_wire_slave_properties

bind ee_two_wire_slave ee_two_wire_slave_properties #(.PROG_CYCLES(PROG_CYCLES)) i_props (
  .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .select_strap_bit0(select_strap_bit0),
  .select_strap_bit1(select_strap_bit1), .select_strap_bit2(select_strap_bit2),
  .writeProtect(writeProtect), .memRdAddr(memRdAddr), .memRdData(memRdData),
  .progValid(progValid), .progReady(progReady), .progAddr(progAddr),
  .progData(progData), .busy(busy), .standby(standby));

// >>> verif/ee_bus_master.sv
// Two-wire bus master model on an open-drain data line
`timescale 1ns/10ps
module ee_bus_master (
  input  wire logic core_clk,
  input  wire logic sdaOe,
  output      logic sclIn,
  output      logic sdaIn
);
  logic sdaDrv; // Master release level, 1 = let go
  // Pull-up wire: low if either side pulls
  assign sdaIn = sdaDrv & ~sdaOe;
  initial
  begin
    sclIn = 1'b1;
    sdaDrv = 1'b1;
  end
  // Step n cycles, landing just past the edge
  task w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : w
  // Lines move on separate steps so no edge pair is misread
  task setSda(input logic v);
    w(8);
    sdaDrv = v;
  endtask : setSda
  task setScl(input logic v);
    w(8);
    sclIn = v;
  endtask : setScl
  // One bit: data moves only while the clock is low
  task bitx(input logic d, output logic q);
    setSda(d);
    setScl(1'b1);
    w(8);
    q = sdaIn;
    sclIn = 1'b0;
  endtask : bitx
  task start;
    setSda(1'b1);
    setScl(1'b1);
    setSda(1'b0);
    setScl(1'b0);
  endtask : start
  task stop;
    setSda(1'b0);
    setScl(1'b1);
    setSda(1'b1);
    w(8);
  endtask : stop
  task wbyte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], q);
    bitx(1'b1, q);
    ack = ~q;
  endtask : wbyte
  // Low answer streams on, high answer ends the read
  task rbyte(input logic mack, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, q);
      b[i] = q;
    end
    bitx(~mack, q);
  endtask : rbyte
  // Address-only frame
  task probe(input logic [7:0] b, output logic ack);
    start();
    wbyte(b, ack);
    stop();
  endtask : probe
  // Clock out a stuck slave until data is high, then start and stop
  task recover;
    setSda(1'b1);
    for (int i = 0; i < 9; i++)
    begin
      setScl(1'b1);
      w(8);
      if (sdaIn === 1'b1)
        break;
      sclIn = 1'b0;
    end
    start();
    stop();
  endtask : recover
endmodule : ee_bus_master

// >>> verif/ee_two_wire_slave_tb_top.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/10ps
module ee_two_wire_slave_tb_top;
  import ee_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              writeProtect = 1'b0;
  logic              progReady = 1'b1;
  logic              clkEn = 1'b1;    // Freezes the design while low
  logic [2:0]        strap = 3'h5;    // Strap levels, address bits 3:1
  logic [3:0]        tick = 4'h0; // Paces writer stalls
  logic              sclIn, sdaIn, sdaOe, progValid, busy, standby, ack;
  logic [ADDR_W-1:0] memRdAddr, progAddr;
  logic [7:0]        progData, d;
  logic [7:0]        mem [8192];  // Array model
  logic [7:0]        refm [8192]; // Expected contents
  int                errors = 0;
  int                checks = 0;
  int                nProg = 0;
  always #50 core_clk = ~core_clk;
  // Writer stalls half the time so the two-entry buffer fills
  always @(posedge core_clk)
  begin
    tick <= tick + 4'h1;
    progReady <= #1 ~tick[2];
    if (progValid === 1'b1 && progReady === 1'b1)
    begin
      mem[progAddr] <= progData;
      nProg <= nProg + 1;
    end
  end
  ee_two_wire_slave #(.PROG_CYCLES(600)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(), .sdaOe(sdaOe), .select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]),
    .select_strap_bit2(strap[2]), .writeProtect(writeProtect), .memRdAddr(memRdAddr),
    .memRdData(mem[memRdAddr]), .progValid(progValid), .progReady(progReady),
    .progAddr(progAddr), .progData(progData), .busy(busy), .standby(standby));
  ee_bus_master i_mst (.core_clk(core_clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // Overfilled page at offset 3, polled while programming
  task automatic t_page;
    i_mst.start();
    i_mst.wbyte(8'haa, ack);
    i_mst.wbyte(8'h01, ack);
    i_mst.wbyte(8'h23, ack);
    for (int k = 0; k < 34; k++)
    begin
      i_mst.wbyte(8'(8'h80 + k), ack);
      refm[{8'h09, 5'(3 + k)}] = 8'(8'h80 + k);
      chk("data ack", 13'h1, 13'(ack));
    end
    i_mst.stop();
    chk("busy", 13'h1, 13'(busy));
    i_mst.probe(8'haa, ack);
    chk("busy poll", 13'h0, 13'(ack));
    for (int i = 0; i < 2000 && busy !== 1'b0; i++)
      i_mst.w(1);
    if (busy !== 1'b0)
    begin
      errors++;
      wrap_up();
    end
    i_mst.probe(8'haa, ack);
    chk("done poll", 13'h1, 13'(ack));
    chk("writes", 13'd32, 13'(nProg));
    for (int k = 0; k < 32; k++)
      chk("page", 13'(refm[13'h0120 + k]), 13'(mem[13'h0120 + k]));
  endtask : t_page
  // Random read across the top, then current reads wrapping to zero
  task automatic t_read;
    i_mst.start();
    i_mst.wbyte(8'haa, ack);
    i_mst.wbyte(8'h1f, ack);
    i_mst.wbyte(8'hfe, ack);
    i_mst.start();
    i_mst.wbyte(8'hab, ack);
    chk("read ack", 13'h1, 13'(ack));
    i_mst.rbyte(1'b1, d);
    chk("rand", 13'(refm[13'h1ffe]), 13'(d));
    i_mst.rbyte(1'b0, d);
    chk("seq", 13'(refm[13'h1fff]), 13'(d));
    i_mst.stop();
    chk("standby", 13'h1, 13'(standby));
    i_mst.start();
    i_mst.wbyte(8'hab, ack);
    for (int k = 0; k < 3; k++)
    begin
      i_mst.rbyte(k < 2, d);
      chk("cur", 13'(refm[k]), 13'(d));
    end
    i_mst.stop();
  endtask : t_read
  initial
  begin
    for (int i = 0; i < 8192; i++)
    begin
      mem[i] = 8'(i) ^ 8'h5a;
      refm[i] = 8'(i) ^ 8'h5a;
    end
    i_mst.w(4);
    rst_n = 1'b1;
    i_mst.w(4);
    chk("rst standby", 13'h1, 13'(standby));
    chk("rst addr", 13'h0, memRdAddr);
    i_mst.probe(8'hba, ack);
    chk("bad prefix", 13'h0, 13'(ack));
    i_mst.probe(8'ha6, ack);
    chk("bad strap", 13'h0, 13'(ack));
    t_page();
    writeProtect = 1'b1;
    i_mst.start();
    i_mst.wbyte(8'haa, ack);
    i_mst.wbyte(8'h00, ack);
    i_mst.wbyte(8'h05, ack);
    i_mst.wbyte(8'h3c, ack);
    i_mst.stop();
    chk("wp busy", 13'h0, 13'(busy));
    chk("wp data", 13'(refm[5]), 13'(mem[5]));
    writeProtect = 1'b0;
    t_read();
    i_mst.start();
    i_mst.wbyte(8'hab, ack);
    i_mst.rbyte(1'b1, d);
    i_mst.recover();
    i_mst.probe(8'haa, ack);
    chk("recovered", 13'h1, 13'(ack));
    // Frozen device must not answer, then straps move the address
    clkEn = 1'b0;
    i_mst.probe(8'haa, ack);
    chk("frozen", 13'h0, 13'(ack));
    clkEn = 1'b1;
    strap = 3'h2;
    i_mst.probe(8'ha4, ack);
    chk("new strap", 13'h1, 13'(ack));
    i_mst.probe(8'haa, ack);
    chk("old strap", 13'h0, 13'(ack));
    wrap_up();
  end
endmodule : ee_two_wire_slave_tb_top
